// ==== shared/pmsm_pkg.sv ====
package pmsm_pkg;

	// ******************************
	// Timing
	// ******************************
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned CARRIER_US    = 100;
	localparam int unsigned CARRIER_TICKS = CLK_HZ / 1_000_000 * CARRIER_US;
	localparam int unsigned SPEED_US      = 1000;
	localparam int unsigned SPEED_TICKS   = CLK_HZ / 1_000_000 * SPEED_US;

	// ******************************
	// Register map, byte addresses
	// ******************************
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_STATUS  = 8'h04;
	localparam logic [7:0] OFS_MASK    = 8'h08;
	localparam logic [7:0] OFS_CMD_U   = 8'h0c;
	localparam logic [7:0] OFS_CMD_V   = 8'h10;
	localparam logic [7:0] OFS_CMD_W   = 8'h14;
	localparam logic [7:0] OFS_VREF    = 8'h18;
	localparam logic [7:0] OFS_SPEED   = 8'h1c;
	localparam logic [7:0] OFS_VBUS    = 8'h20;
	localparam logic [7:0] OFS_CURRENT = 8'h24;
	localparam logic [7:0] OFS_RATIO   = 8'h28;
	localparam logic [7:0] OFS_LEVEL   = 8'h2c;

	// ******************************
	// Fields and reset values
	// ******************************
	localparam int unsigned ST_OC      = 0;
	localparam int unsigned ST_CARRIER = 1;
	localparam int unsigned ST_SPEED   = 2;
	localparam int unsigned ST_OV      = 3;
	localparam int unsigned ST_UV      = 4;
	localparam int unsigned ST_W       = 5;
	localparam int unsigned SPEED_DIR_BIT = 16;
	localparam logic [ST_W-1:0] MASK_RESET = 5'h00;

	localparam logic [3:0] LVL_OC      = 4'h0;
	localparam logic [3:0] LVL_CARRIER = 4'h5;
	localparam logic [3:0] LVL_SPEED   = 4'ha;
	localparam logic [3:0] LVL_NONE    = 4'hf;

	// ******************************
	// Scaling
	// ******************************
	localparam logic [11:0] CODE_MID      = 12'h800;
	localparam logic [11:0] CODE_CCW_TOP  = 12'h7ff;
	localparam int          SPEED_MAX_RPM = 2400;
	localparam int          SPEED_SHIFT   = 14;
	localparam int          SPEED_MUL     = (SPEED_MAX_RPM * (1 << SPEED_SHIFT) + 2046) / 2047;
	localparam int          VBUS_FULL_MV  = 73260;
	localparam int          VBUS_SHIFT    = 12;
	localparam int          VBUS_MUL      = (VBUS_FULL_MV * (1 << VBUS_SHIFT) + 4094) / 4095;
	localparam int          CUR_FULL_MA   = 8250;
	localparam int          CUR_SHIFT     = 11;
	localparam int          OV_LIMIT_V    = 60;
	localparam int          UV_LIMIT_V    = 8;
	localparam logic [16:0] OV_MV         = 17'(OV_LIMIT_V * 1000);
	localparam logic [16:0] UV_MV         = 17'(UV_LIMIT_V * 1000);
	localparam logic [15:0] SQRT3_HALF_Q15 = 16'h6eda;

	typedef enum logic {
		MOD_SINE         = 1'b0,
		MOD_SPACE_VECTOR = 1'b1
	} mod_method_e;

	typedef enum logic {
		DIV_IDLE = 1'b0,
		DIV_RUN  = 1'b1
	} div_state_e;

	typedef struct packed {
		logic [11:0] speed_code;
		logic [11:0] vbus_code;
		logic [11:0] current_code;
	} adc_sample_s;

	typedef struct packed {
		logic signed [16:0] u;
		logic signed [16:0] v;
		logic signed [16:0] w;
	} mod_wave_s;

endpackage

// ==== hw/lin_scale.sv ====
`timescale 1ns/1ps

// Signed linear scaler: out = (in * MUL) >>> SHIFT, registered on enable.
module lin_scale #(
	parameter int IN_W  = 13,
	parameter int OUT_W = 16,
	parameter int MUL   = 1,
	parameter int SHIFT = 0
) (
	input  wire logic                    clk_sys_i,
	input  wire logic                    reset_n_i,
	input  wire logic                    enable_i,
	input  wire logic signed [IN_W-1:0]  value_i,
	output logic signed      [OUT_W-1:0] scaled_o
);

	localparam int PROD_W = IN_W + 20;

	if (IN_W < 2 || OUT_W < 2 || SHIFT < 0 || MUL < 1 || MUL >= (1 << 19))
	begin : g_bad
		$error("lin_scale: unsupported parameters");
	end

	logic signed [PROD_W-1:0] product;
	logic signed [PROD_W-1:0] shifted;

	assign product = PROD_W'(value_i) * PROD_W'(signed'(MUL));
	assign shifted = product >>> SHIFT;

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			scaled_o <= '0;
		else if (enable_i)
			scaled_o <= shifted[OUT_W-1:0];
	end

endmodule // lin_scale

// ==== hw/pmsm_scaling_modulator.sv ====
`timescale 1ns/1ps

// How it works
// - The motor runs while the filtered run switch reads high and no fault flag is set, and stops while it reads low.
// - Clockwise, speed codes 0x800 to 0xfff map linearly onto 0 to 2400 rpm.
// - Counter-clockwise, speed codes 0x7ff down to 0x000 map linearly onto 0 to 2400 rpm.
// - Bus-voltage codes 0x000 to 0xfff map linearly onto 0 to 73.26 V.
// - The scaled bus voltage feeds the ratio and the over/under-voltage checks that halt PWM.
// - Current codes 0x000 to 0xfff map linearly onto -8.25 A to +8.245 A.
// - In sine mode the ratio is the reference voltage over the bus voltage.
// - In space-vector mode the mean of max and min command is subtracted from each command.
// - Space-vector ratio uses the reference scaled by root three over two, over the bus voltage.
// - Event levels are over-current 0, carrier overflow 5 and speed timer 10, lowest first.
// - A low over-current input forces all PWM outputs to high impedance.
// - All six outputs are disabled when the bus exceeds 60 V, checked each control period.
module pmsm_scaling_modulator #(
	parameter int unsigned SPEED_TICKS = pmsm_pkg::SPEED_TICKS
) (
	input  wire logic                 clk_sys_i,
	input  wire logic                 reset_n_i,
	input  wire logic [7:0]           avs_address_i,
	input  wire logic                 avs_read_i,
	input  wire logic                 avs_write_i,
	input  wire logic [31:0]          avs_writedata_i,
	input  wire logic [3:0]           avs_byteenable_i,
	output logic [31:0]               avs_readdata_o,
	output logic                      avs_waitrequest_o,
	input  wire logic                 run_switch_i,
	input  wire logic                 overcurrent_n_i,
	input  wire pmsm_pkg::adc_sample_s adc_i,
	input  wire logic                 adc_valid_i,
	output logic                      run_o,
	output logic [5:0]                pwm_enable_o,
	output logic                      pwm_hiz_o,
	output pmsm_pkg::mod_wave_s       wave_o,
	output logic                      irq_o
);

	if (SPEED_TICKS < 2 || SPEED_TICKS > 65536)
	begin : g_bad
		$error("pmsm_scaling_modulator: SPEED_TICKS out of range");
	end

	// ******************************
	// Pin synchronisers
	// ******************************
	logic [2:0] run_sync;
	logic [2:0] ocn_sync;
	logic       run_level;
	logic       ocn_level;

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			run_sync  <= 3'h0;
			ocn_sync  <= 3'h7;
			run_level <= 1'b0;
			ocn_level <= 1'b1;
		end
		else
		begin
			run_sync <= {run_sync[1:0], run_switch_i};
			ocn_sync <= {ocn_sync[1:0], overcurrent_n_i};
			if (run_sync[2] == run_sync[1])
				run_level <= run_sync[1];
			if (ocn_sync[2] == ocn_sync[1])
				ocn_level <= ocn_sync[1];
		end
	end

	// ******************************
	// Carrier and speed timers
	// ******************************
	logic [11:0] carrier_cnt;
	logic [15:0] speed_cnt;
	logic        ctrl_tick;
	logic        speed_tick;
	wire         carrier_wrap = carrier_cnt == 12'(pmsm_pkg::CARRIER_TICKS - 1);
	wire         speed_wrap   = speed_cnt == 16'(SPEED_TICKS - 1);

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			carrier_cnt <= 12'h000;
			speed_cnt   <= 16'h0000;
			ctrl_tick   <= 1'b0;
			speed_tick  <= 1'b0;
		end
		else
		begin
			carrier_cnt <= carrier_wrap ? 12'h000 : carrier_cnt + 12'h001;
			speed_cnt   <= speed_wrap ? 16'h0000 : speed_cnt + 16'h0001;
			ctrl_tick   <= carrier_wrap;
			speed_tick  <= speed_wrap;
		end
	end

	// ******************************
	// Converter scaling
	// ******************************
	wire        code_cw   = adc_i.speed_code >= pmsm_pkg::CODE_MID;
	wire [11:0] speed_mag = code_cw ? adc_i.speed_code - pmsm_pkg::CODE_MID
	                                : pmsm_pkg::CODE_CCW_TOP - adc_i.speed_code;
	wire signed [12:0] cur_centred = signed'({1'b0, adc_i.current_code})
	                               - signed'({1'b0, pmsm_pkg::CODE_MID});
	logic signed [12:0] speed_rpm;
	logic signed [17:0] vbus_mv_s;
	logic signed [15:0] current_ma;
	logic               speed_ccw;
	wire [16:0]         vbus_mv = vbus_mv_s[16:0];

	lin_scale #(.IN_W(13), .OUT_W(13), .MUL(pmsm_pkg::SPEED_MUL), .SHIFT(pmsm_pkg::SPEED_SHIFT))
	u_speed (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.enable_i  (adc_valid_i),
		.value_i   (signed'({1'b0, speed_mag})),
		.scaled_o  (speed_rpm)
	);

	lin_scale #(.IN_W(13), .OUT_W(18), .MUL(pmsm_pkg::VBUS_MUL), .SHIFT(pmsm_pkg::VBUS_SHIFT))
	u_vbus (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.enable_i  (adc_valid_i),
		.value_i   (signed'({1'b0, adc_i.vbus_code})),
		.scaled_o  (vbus_mv_s)
	);

	lin_scale #(.IN_W(13), .OUT_W(16), .MUL(pmsm_pkg::CUR_FULL_MA), .SHIFT(pmsm_pkg::CUR_SHIFT))
	u_current (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.enable_i  (adc_valid_i),
		.value_i   (cur_centred),
		.scaled_o  (current_ma)
	);

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			speed_ccw <= 1'b0;
		else if (adc_valid_i)
			speed_ccw <= ~code_cw;
	end

	// ******************************
	// Register bus
	// ******************************
	logic                         mod_sel;
	logic [pmsm_pkg::ST_W-1:0]    status;
	logic [pmsm_pkg::ST_W-1:0]    mask;
	logic signed [15:0]           cmd_u;
	logic signed [15:0]           cmd_v;
	logic signed [15:0]           cmd_w;
	logic [15:0]                  vref;
	logic [15:0]                  ratio;
	logic [3:0]                   level;
	logic [31:0]                  rd_mux;

	wire bus_req  = (avs_read_i | avs_write_i) & avs_waitrequest_o;
	wire wr_take  = avs_write_i & ~avs_waitrequest_o;
	wire wr_ctrl  = wr_take & avs_address_i == pmsm_pkg::OFS_CTRL & avs_byteenable_i[0];
	wire wr_stat  = wr_take & avs_address_i == pmsm_pkg::OFS_STATUS & avs_byteenable_i[0];
	wire wr_mask  = wr_take & avs_address_i == pmsm_pkg::OFS_MASK & avs_byteenable_i[0];
	wire wr_u     = wr_take & avs_address_i == pmsm_pkg::OFS_CMD_U;
	wire wr_v     = wr_take & avs_address_i == pmsm_pkg::OFS_CMD_V;
	wire wr_w     = wr_take & avs_address_i == pmsm_pkg::OFS_CMD_W;
	wire wr_vref  = wr_take & avs_address_i == pmsm_pkg::OFS_VREF;
	wire [15:0] be_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	wire [15:0] wdata16 = avs_writedata_i[15:0];

	always_comb
	begin
		case (avs_address_i)
			pmsm_pkg::OFS_CTRL:    rd_mux = {31'h0, mod_sel};
			pmsm_pkg::OFS_STATUS:  rd_mux = {27'h0, status};
			pmsm_pkg::OFS_MASK:    rd_mux = {27'h0, mask};
			pmsm_pkg::OFS_CMD_U:   rd_mux = {16'h0, cmd_u};
			pmsm_pkg::OFS_CMD_V:   rd_mux = {16'h0, cmd_v};
			pmsm_pkg::OFS_CMD_W:   rd_mux = {16'h0, cmd_w};
			pmsm_pkg::OFS_VREF:    rd_mux = {16'h0, vref};
			pmsm_pkg::OFS_SPEED:   rd_mux = {15'h0, speed_ccw, 4'h0, speed_rpm[11:0]};
			pmsm_pkg::OFS_VBUS:    rd_mux = {15'h0, vbus_mv};
			pmsm_pkg::OFS_CURRENT: rd_mux = {16'h0, current_ma};
			pmsm_pkg::OFS_RATIO:   rd_mux = {16'h0, ratio};
			pmsm_pkg::OFS_LEVEL:   rd_mux = {28'h0, level};
			default:               rd_mux = 32'h0;
		endcase
	end

	// A request is answered on the second edge; the idle high waitrequest keeps it simple.
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h0;
		end
		else
		begin
			avs_waitrequest_o <= ~bus_req;
			if (bus_req & avs_read_i)
				avs_readdata_o <= rd_mux;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			mod_sel <= pmsm_pkg::MOD_SINE;
			mask    <= pmsm_pkg::MASK_RESET;
			cmd_u   <= 16'h0;
			cmd_v   <= 16'h0;
			cmd_w   <= 16'h0;
			vref    <= 16'h0;
		end
		else
		begin
			if (wr_ctrl)
				mod_sel <= avs_writedata_i[0];
			if (wr_mask)
				mask <= avs_writedata_i[pmsm_pkg::ST_W-1:0];
			if (wr_u)
				cmd_u <= (cmd_u & ~be_mask) | (wdata16 & be_mask);
			if (wr_v)
				cmd_v <= (cmd_v & ~be_mask) | (wdata16 & be_mask);
			if (wr_w)
				cmd_w <= (cmd_w & ~be_mask) | (wdata16 & be_mask);
			if (wr_vref)
				vref <= (vref & ~be_mask) | (wdata16 & be_mask);
		end
	end

	// ******************************
	// Events, protection and outputs
	// ******************************
	wire ov_hit = ctrl_tick & (vbus_mv > pmsm_pkg::OV_MV);
	wire uv_hit = ctrl_tick & (vbus_mv < pmsm_pkg::UV_MV);
	wire [pmsm_pkg::ST_W-1:0] ev_set = {uv_hit, ov_hit, speed_tick, ctrl_tick, ~ocn_level};
	wire [pmsm_pkg::ST_W-1:0] ev_clr = wr_stat ? avs_writedata_i[pmsm_pkg::ST_W-1:0] : '0;
	wire [pmsm_pkg::ST_W-1:0] next_status = (status & ~ev_clr) | ev_set;
	wire [pmsm_pkg::ST_W-1:0] pend = status & mask;
	wire fault = status[pmsm_pkg::ST_OC] | status[pmsm_pkg::ST_OV] | status[pmsm_pkg::ST_UV];
	wire drive = run_level & ~fault;
	wire [3:0] next_level = pend[pmsm_pkg::ST_OC]      ? pmsm_pkg::LVL_OC :
	                        pend[pmsm_pkg::ST_CARRIER] ? pmsm_pkg::LVL_CARRIER :
	                        pend[pmsm_pkg::ST_SPEED]   ? pmsm_pkg::LVL_SPEED :
	                                                     pmsm_pkg::LVL_NONE;

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			status       <= '0;
			level        <= pmsm_pkg::LVL_NONE;
			irq_o        <= 1'b0;
			run_o        <= 1'b0;
			pwm_enable_o <= 6'h00;
			pwm_hiz_o    <= 1'b0;
		end
		else
		begin
			status       <= next_status;
			level        <= next_level;
			irq_o        <= |pend;
			run_o        <= drive;
			pwm_enable_o <= {6{drive}};
			pwm_hiz_o    <= ~ocn_level | status[pmsm_pkg::ST_OC];
		end
	end

	// ******************************
	// Modulation waves
	// ******************************
	wire signed [15:0] max_uv = cmd_u > cmd_v ? cmd_u : cmd_v;
	wire signed [15:0] min_uv = cmd_u < cmd_v ? cmd_u : cmd_v;
	wire signed [15:0] v_max  = max_uv > cmd_w ? max_uv : cmd_w;
	wire signed [15:0] v_min  = min_uv < cmd_w ? min_uv : cmd_w;
	wire signed [16:0] v_sum  = 17'(v_max) + 17'(v_min);
	wire signed [16:0] delta  = mod_sel ? v_sum >>> 1 : 17'sh0;
	wire [31:0]        peak_p = vref * pmsm_pkg::SQRT3_HALF_Q15;
	wire [15:0]        num    = mod_sel ? peak_p[30:15] : vref;

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			wave_o <= '0;
		else if (ctrl_tick)
		begin
			wave_o.u <= 17'(cmd_u) - delta;
			wave_o.v <= 17'(cmd_v) - delta;
			wave_o.w <= 17'(cmd_w) - delta;
		end
	end

	// ******************************
	// Ratio divider, Q1.15
	// ******************************
	// Sixteen steps per control period; a ratio of two or more saturates rather than wraps.
	// The divisor is held for the whole division so that a fresh sample cannot skew it.
	pmsm_pkg::div_state_e div_state;
	logic [17:0] rem;
	logic [15:0] quo;
	logic [4:0]  step;
	logic [16:0] divisor;
	wire  [17:0] rem_sub = rem - {1'b0, divisor};
	wire         sat     = vbus_mv == 17'h0 || {2'b00, num} >= {vbus_mv, 1'b0};

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			div_state <= pmsm_pkg::DIV_IDLE;
			rem       <= 18'h0;
			quo       <= 16'h0;
			step      <= 5'h0;
			divisor   <= 17'h0;
			ratio     <= 16'h0;
		end
		else
		begin
			case (div_state)
				pmsm_pkg::DIV_IDLE:
					if (ctrl_tick & sat)
						ratio <= 16'hffff;
					else if (ctrl_tick)
					begin
						rem       <= {2'b00, num};
						divisor   <= vbus_mv;
						step      <= 5'h0;
						div_state <= pmsm_pkg::DIV_RUN;
					end
				pmsm_pkg::DIV_RUN:
				begin
					quo  <= {quo[14:0], ~rem_sub[17]};
					rem  <= {(rem_sub[17] ? rem[16:0] : rem_sub[16:0]), 1'b0};
					step <= step + 5'h1;
					if (step == 5'hf)
					begin
						ratio     <= {quo[14:0], ~rem_sub[17]};
						div_state <= pmsm_pkg::DIV_IDLE;
					end
				end
				default:
					div_state <= pmsm_pkg::DIV_IDLE;
			endcase
		end
	end

	// ******************************
	// Assertions
	// ******************************
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);

	a_run_follows: assert property (run_level && !fault |=> run_o)
		else $error("run output did not follow the switch");
	a_speed_cw: assert property (adc_valid_i && adc_i.speed_code == 12'hfff
		|=> speed_rpm == 13'sd2400 && !speed_ccw)
		else $error("full clockwise code is not 2400 rpm");
	a_speed_ccw: assert property (adc_valid_i && adc_i.speed_code == 12'h000
		|=> speed_rpm == 13'sd2400 && speed_ccw)
		else $error("full counter-clockwise code is not 2400 rpm");
	a_vbus_full: assert property (adc_valid_i && adc_i.vbus_code == 12'hfff
		|=> vbus_mv == 17'd73260)
		else $error("full bus code is not 73.26 V");
	a_cur_zero: assert property (adc_valid_i && adc_i.current_code == 12'h800
		|=> current_ma == 16'sd0)
		else $error("mid-scale current is not zero");
	a_cur_floor: assert property (adc_valid_i && adc_i.current_code == 12'h000
		|=> current_ma == -16'sd8250)
		else $error("zero current code is not -8.25 A");
	a_ov_halt: assert property (ov_hit |-> ##2 pwm_enable_o == 6'h00)
		else $error("outputs stayed on above the voltage limit");
	a_uv_halt: assert property (uv_hit |-> ##2 !run_o)
		else $error("drive stayed on below the voltage limit");
	a_oc_hiz: assert property ($fell(ocn_level) |=> pwm_hiz_o ##1 pwm_hiz_o)
		else $error("outputs not floated on over-current");
	a_sv_wave: assert property (ctrl_tick && mod_sel |=>
		wave_o.u + wave_o.v + wave_o.w == $past(cmd_u) + $past(cmd_v) + $past(cmd_w)
		- 3 * ($past(v_sum) >>> 1))
		else $error("space-vector offset not applied");
	a_prio_order: assert property (pend[pmsm_pkg::ST_OC] |=> level == pmsm_pkg::LVL_OC)
		else $error("over-current not at top priority");
	a_ratio_sine: assert property (div_state == pmsm_pkg::DIV_IDLE && ctrl_tick && !sat
		&& !mod_sel && {1'b0, vref} == vbus_mv && vbus_mv != 17'h0 |-> ##17 ratio == 16'h8000)
		else $error("unit sine ratio is not 0x8000");
	a_bus_answer: assert property (bus_req |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("bus answer is not one cycle");

	c_oc_event: cover property ($fell(ocn_level) ##[1:8] pwm_hiz_o);
	c_sv_tick:  cover property (mod_sel && ctrl_tick);
	c_ratio:    cover property (div_state == pmsm_pkg::DIV_RUN ##16 ratio != 16'h0);
	c_irq:      cover property ($rose(irq_o));

endmodule // pmsm_scaling_modulator

// ==== dv/pmsm_plant_model.sv ====
`timescale 1ns/1ps

// ****************************************
// Inverter, shunt amplifier and motor stand-in
// ****************************************
module pmsm_plant_model (
	input  wire logic                  clk_sys_i,
	input  wire logic                  reset_n_i,
	input  wire pmsm_pkg::adc_sample_s codes_i,
	input  wire logic                  fault_i,
	output pmsm_pkg::adc_sample_s      adc_o,
	output logic                       adc_valid_o,
	output logic                       overcurrent_n_o
);
	logic [2:0] tick;

	// The comparator output idles high through its pull-up and drops on a fault.
	assign overcurrent_n_o = ~fault_i;

	// Between conversions the codes are inverted, so a design that samples off the strobe fails.
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			tick        <= 3'h0;
			adc_o       <= '0;
			adc_valid_o <= 1'b0;
		end
		else
		begin
			tick        <= tick + 3'h1;
			adc_valid_o <= (tick == 3'h7);
			adc_o       <= (tick == 3'h7) ? codes_i : ~codes_i;
		end
	end
endmodule // pmsm_plant_model

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
	// ****************************************
	// Signals
	// ****************************************
	logic                  clk_sys_i = 1'b0;
	logic                  reset_n_i = 1'b0;
	logic [7:0]            addr      = 8'h00;
	logic                  rd        = 1'b0;
	logic                  wr        = 1'b0;
	logic [31:0]           wdata     = 32'h0;
	logic                  run_sw    = 1'b0;
	logic                  fault     = 1'b0;
	pmsm_pkg::adc_sample_s codes     = '0;
	pmsm_pkg::adc_sample_s adc;
	pmsm_pkg::mod_wave_s   wave;
	logic                  adc_valid;
	logic                  oc_n;
	logic                  run_o;
	logic                  irq_o;
	logic                  hiz;
	logic                  wreq;
	logic [5:0]            pwm_en;
	logic [31:0]           rdata;
	logic [31:0]           got;
	logic [11:0]           s;
	logic [11:0]           v;
	logic [11:0]           c;
	logic [11:0]           corner [4] = '{12'h000, 12'h7ff, 12'h800, 12'hfff};
	int                    cmd [3]    = '{6000, -2000, -4000};
	int                    bad_count   = 0;
	int                    check_count = 0;
	int                    seed;

	always #12.5 clk_sys_i = ~clk_sys_i;

	// A short speed period keeps the speed event busy without lengthening the run.
	pmsm_scaling_modulator #(.SPEED_TICKS(50)) dut (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .run_switch_i(run_sw),
		.overcurrent_n_i(oc_n), .adc_i(adc), .adc_valid_i(adc_valid), .run_o(run_o),
		.pwm_enable_o(pwm_en), .pwm_hiz_o(hiz), .wave_o(wave), .irq_o(irq_o));

	pmsm_plant_model plant (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .codes_i(codes), .fault_i(fault),
		.adc_o(adc), .adc_valid_o(adc_valid), .overcurrent_n_o(oc_n));

	// ****************************************
	// Expectations
	// ****************************************
	function automatic logic [31:0] exp_speed(input logic [11:0] k);
		if (k >= 12'h800)
			return 32'((longint'(k - 12'h800) * pmsm_pkg::SPEED_MUL) >> pmsm_pkg::SPEED_SHIFT);
		return 32'h10000 | 32'((longint'(12'h7ff - k) * pmsm_pkg::SPEED_MUL) >> 14);
	endfunction

	function automatic logic [31:0] exp_vbus(input logic [11:0] k);
		return 32'((longint'(k) * pmsm_pkg::VBUS_MUL) >> pmsm_pkg::VBUS_SHIFT);
	endfunction

	function automatic logic [31:0] exp_cur(input logic [11:0] k);
		return 32'((((longint'(k) - 2048) * pmsm_pkg::CUR_FULL_MA) >>> 11) & 32'hffff);
	endfunction

	function automatic logic [31:0] exp_ratio(input longint vref, input longint vb, input int m);
		longint r;
		r = ((m != 0) ? ((vref * 28378) >> 15) : vref) * 32768 / vb;
		return (r > 65535) ? 32'hffff : 32'(r);
	endfunction

	// ****************************************
	// Tasks
	// ****************************************
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %0t %s got %h expected %h", $time, m, g, e);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	// The request stays up until waitrequest is seen low at a rising edge.
	// Read just after the edge, wreq and rdata hold what the design showed at that edge.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		addr  <= a;
		wdata <= d;
		rd    <= ~w;
		wr    <= w;
		do
		begin
			@(posedge clk_sys_i);
			n++;
		end
		while (wreq !== 1'b0 && n < 20);
		if (wreq !== 1'b0)
		begin
			bad_count++;
			$display("[ERR] %0t bus answer missing", $time);
			give_verdict();
		end
		else
		begin
			got = rdata;
			rd <= 1'b0;
			wr <= 1'b0;
		end
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		seed = $urandom(32'h76334d4c);
		repeat (5) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		@(negedge clk_sys_i);
		chk({31'h0, wreq}, 32'h1, "idle waitrequest");
		chk({31'h0, run_o}, 32'h0, "run after reset");
		bus(1'b0, pmsm_pkg::OFS_MASK, 32'h0);
		chk(got, 32'(pmsm_pkg::MASK_RESET), "mask reset");
		bus(1'b0, 8'h30, 32'h0);
		chk(got, 32'h0, "unmapped read");
		$display("test reset done");

		for (int i = 0; i < 16; i++)
		begin
			s = (i < 4) ? corner[i] : 12'($urandom);
			v = (i < 4) ? corner[3 - i] : 12'($urandom);
			c = (i < 4) ? corner[i] : 12'($urandom);
			codes <= {s, v, c};
			wait_cyc(12);
			bus(1'b0, pmsm_pkg::OFS_SPEED, 32'h0);
			chk(got, exp_speed(s), "speed");
			bus(1'b0, pmsm_pkg::OFS_VBUS, 32'h0);
			chk(got, exp_vbus(v), "bus voltage");
			bus(1'b0, pmsm_pkg::OFS_CURRENT, 32'h0);
			chk(got, exp_cur(c), "current");
		end
		codes <= {12'h800, 12'h800, 12'h800};
		$display("test scaling done");

		run_sw <= 1'b1;
		wait_cyc(4100);
		bus(1'b1, pmsm_pkg::OFS_STATUS, 32'h1f);
		wait_cyc(20);
		chk({31'h0, run_o}, 32'h1, "run high");
		chk({26'h0, pwm_en}, 32'h3f, "outputs on");
		chk({31'h0, hiz}, 32'h0, "pins driven");
		$display("test run done");

		for (int m = 0; m < 2; m++)
		begin
			bus(1'b1, pmsm_pkg::OFS_CTRL, 32'(m));
			bus(1'b1, pmsm_pkg::OFS_CMD_U, 32'(cmd[0]));
			bus(1'b1, pmsm_pkg::OFS_CMD_V, 32'(cmd[1]));
			bus(1'b1, pmsm_pkg::OFS_CMD_W, 32'(cmd[2]));
			bus(1'b1, pmsm_pkg::OFS_VREF, 32'd18000);
			wait_cyc(4100);
			chk(32'(wave.u), 32'(cmd[0] - m * 1000), "wave u");
			chk(32'(wave.v), 32'(cmd[1] - m * 1000), "wave v");
			chk(32'(wave.w), 32'(cmd[2] - m * 1000), "wave w");
			bus(1'b0, pmsm_pkg::OFS_RATIO, 32'h0);
			chk(got, exp_ratio(18000, exp_vbus(12'h800), m), "ratio");
		end
		bus(1'b1, pmsm_pkg::OFS_CTRL, 32'h0);
		bus(1'b1, pmsm_pkg::OFS_VREF, exp_vbus(12'h800));
		wait_cyc(4100);
		bus(1'b0, pmsm_pkg::OFS_RATIO, 32'h0);
		chk(got, exp_ratio(exp_vbus(12'h800), exp_vbus(12'h800), 0), "unit ratio");
		$display("test modulation done");

		bus(1'b1, pmsm_pkg::OFS_MASK, 32'h6);
		bus(1'b0, pmsm_pkg::OFS_LEVEL, 32'h0);
		chk(got, 32'(pmsm_pkg::LVL_CARRIER), "carrier level");
		chk({31'h0, irq_o}, 32'h1, "irq raised");
		bus(1'b1, pmsm_pkg::OFS_MASK, 32'h4);
		bus(1'b0, pmsm_pkg::OFS_LEVEL, 32'h0);
		chk(got, 32'(pmsm_pkg::LVL_SPEED), "speed level");
		bus(1'b1, pmsm_pkg::OFS_MASK, 32'h0);
		bus(1'b0, pmsm_pkg::OFS_LEVEL, 32'h0);
		chk(got, 32'(pmsm_pkg::LVL_NONE), "no level");
		wait_cyc(2);
		chk({31'h0, irq_o}, 32'h0, "irq masked");
		bus(1'b1, pmsm_pkg::OFS_STATUS, 32'h2);
		bus(1'b0, pmsm_pkg::OFS_STATUS, 32'h0);
		chk(got & 32'h2, 32'h0, "carrier cleared");
		$display("test events done");

		fault <= 1'b1;
		wait_cyc(10);
		chk({31'h0, hiz}, 32'h1, "pins floated");
		chk({31'h0, run_o}, 32'h0, "fault stops run");
		bus(1'b1, pmsm_pkg::OFS_MASK, 32'h7);
		bus(1'b0, pmsm_pkg::OFS_LEVEL, 32'h0);
		chk(got, 32'(pmsm_pkg::LVL_OC), "over-current level");
		fault <= 1'b0;
		wait_cyc(10);
		bus(1'b1, pmsm_pkg::OFS_STATUS, 32'h1f);
		wait_cyc(10);
		chk({31'h0, hiz}, 32'h0, "pins released");
		chk({31'h0, run_o}, 32'h1, "run resumed");
		run_sw <= 1'b0;
		wait_cyc(10);
		chk({31'h0, run_o}, 32'h0, "switch low stops");
		run_sw <= 1'b1;
		wait_cyc(10);
		chk({31'h0, run_o}, 32'h1, "switch high runs");
		$display("test over-current done");

		codes <= {12'h800, 12'he00, 12'h800};
		wait_cyc(4100);
		chk({26'h0, pwm_en}, 32'h0, "over-voltage halt");
		bus(1'b0, pmsm_pkg::OFS_STATUS, 32'h0);
		chk(got & 32'h8, 32'h8, "over-voltage flag");
		codes <= {12'h800, 12'h050, 12'h800};
		wait_cyc(20);
		bus(1'b1, pmsm_pkg::OFS_STATUS, 32'h1f);
		wait_cyc(4100);
		bus(1'b0, pmsm_pkg::OFS_STATUS, 32'h0);
		chk(got & 32'h18, 32'h10, "under-voltage flag");
		chk({26'h0, pwm_en}, 32'h0, "under-voltage halt");
		bus(1'b0, pmsm_pkg::OFS_RATIO, 32'h0);
		chk(got, exp_ratio(exp_vbus(12'h800), exp_vbus(12'h050), 0), "ratio saturated");
		$display("test bus voltage done");
		give_verdict();
	end
endmodule // tb_top
